// >>> hdl/pif_pkg.sv
// Package for the peripheral interrupt flag block: offsets, fields, types
// Notes on behaviour
// RULE1 - Parallel port access flag sets on each completed external port read or write.
// RULE2 - On 28-pin variants the parallel port access flag reads zero always.
// RULE3 - Conversion done flag sets on conversion end, held until software writes zero.
// RULE4 - Receive full flag is read-only, mirrors receive holding register occupancy.
// RULE5 - Transmit empty flag is read-only, high while transmit holding register empty.
// RULE6 - Synchronous serial done flag sets on transfer completion, cleared by software.
// RULE7 - Capture/compare one flag sets on capture or match per mode; unused in PWM.
// RULE8 - Period match flag sets when timer two count equals its period.
// RULE9 - Timer one overflow flag sets on overflow, held until software writes zero.
// RULE10 - Flags latch events regardless of any enable or global enable bit.
// RULE11 - Software should clear a flag before enabling and after servicing it.
// RULE12 - High register flags latch until cleared by software; bit 5 reads zero.
package pif_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] PIF_OFS_FLAGS_LO = 8'h00;
   localparam logic [7:0] PIF_OFS_FLAGS_HI = 8'h04;
   localparam logic [7:0] PIF_OFS_CAPCMP   = 8'h08;

   // Low flag register bit positions
   localparam int PIF_LO_PSP  = 7;
   localparam int PIF_LO_CONV = 6;
   localparam int PIF_LO_RX   = 5;
   localparam int PIF_LO_TX   = 4;
   localparam int PIF_LO_SSP  = 3;
   localparam int PIF_LO_CC1  = 2;
   localparam int PIF_LO_PER  = 1;
   localparam int PIF_LO_T1OV = 0;

   // High flag register bit positions
   localparam int PIF_HI_OSCF = 7;
   localparam int PIF_HI_CMP  = 6;
   localparam int PIF_HI_RSVD = 5;
   localparam int PIF_HI_NVM  = 4;
   localparam int PIF_HI_BCOL = 3;
   localparam int PIF_HI_VDET = 2;
   localparam int PIF_HI_T3OV = 1;
   localparam int PIF_HI_CC2  = 0;

   // Mode control register field positions
   localparam int PIF_CC1_MODE_LSB = 0;
   localparam int PIF_CC2_MODE_LSB = 2;

   // Values after reset
   localparam logic [7:0] PIF_FLAGS_LO_RST = 8'h00;
   localparam logic [7:0] PIF_FLAGS_HI_RST = 8'h00;
   localparam logic [3:0] PIF_CAPCMP_RST   = 4'h0;

   // Software-writable masks (read-only and reserved bits excluded)
   localparam logic [7:0] PIF_LO_WMASK = 8'hCF;
   localparam logic [7:0] PIF_HI_WMASK = 8'hDF;

   // Capture/compare unit operating mode
   typedef enum logic [1:0] {
      PIF_CC_OFF     = 2'h0,
      PIF_CC_CAPTURE = 2'h1,
      PIF_CC_COMPARE = 2'h3,
      PIF_CC_PWM     = 2'h2
   } pif_cc_mode_t;

   // Event reports from the on-chip peripherals, all on ref_clk
   typedef struct packed {
      logic       psp_rw_done;
      logic       conv_done;
      logic       rx_holding_full;
      logic       tx_holding_empty;
      logic       sync_serial_done;
      logic       cc1_capture;
      logic       cc1_compare;
      logic [7:0] timer_two_count;
      logic [7:0] timer_two_period;
      logic       timer_one_ovf;
      logic       osc_fail;
      logic       comparator_change;
      logic       nvm_write_done;
      logic       bus_collision;
      logic       voltage_detect;
      logic       timer_three_ovf;
      logic       cc2_capture;
      logic       cc2_compare;
   } pif_evt_t;

   // Bus slave handshake state
   typedef enum logic {
      PIF_BUS_IDLE = 1'b0,
      PIF_BUS_ACK  = 1'b1
   } pif_bus_t;

endpackage

// >>> hdl/pif_irq_flags.sv
// Peripheral interrupt request flag registers with an Avalon-MM slave
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module pif_irq_flags
   import pif_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter bit PIN28  = 1'b0
) (
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire logic              ce,
   input  wire pif_evt_t          evt,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   output logic [7:0]             flags_lo,
   output logic [7:0]             flags_hi
);

   logic [7:0]   flags_lo_r;
   logic [7:0]   flags_lo_nxt;
   logic [7:0]   flags_hi_r;
   logic [7:0]   flags_hi_nxt;
   logic [3:0]   capcmp_r;
   logic [31:0]  rdata_r;
   logic [31:0]  rdata_nxt;
   pif_bus_t     bus_r;
   logic         per_eq_r;
   logic         per_eq;
   logic         per_hit;
   logic         req;
   logic         take;
   logic         wr_take;
   logic         sel_lo;
   logic         sel_hi;
   logic         sel_cc;
   logic         lane0;
   logic [7:0]   wbyte;
   logic [7:0]   set_lo;
   logic [7:0]   set_hi;
   logic         cc1_evt;
   logic         cc2_evt;
   pif_cc_mode_t cc1_mode;
   pif_cc_mode_t cc2_mode;

   assign req     = avs_read | avs_write;
   assign take    = (bus_r == PIF_BUS_ACK) & req;
   assign wr_take = take & avs_write;
   assign lane0   = avs_byteenable[0];
   assign wbyte   = avs_writedata[7:0];

   // Address decode against the full byte address
   always_comb begin
      sel_lo = 1'b0;
      sel_hi = 1'b0;
      sel_cc = 1'b0;
      if (avs_address == ADDR_W'(PIF_OFS_FLAGS_LO)) begin
         sel_lo = 1'b1;
      end else if (avs_address == ADDR_W'(PIF_OFS_FLAGS_HI)) begin
         sel_hi = 1'b1;
      end else if (avs_address == ADDR_W'(PIF_OFS_CAPCMP)) begin
         sel_cc = 1'b1;
      end
   end

   assign cc1_mode = pif_cc_mode_t'(capcmp_r[PIF_CC1_MODE_LSB +: 2]);
   assign cc2_mode = pif_cc_mode_t'(capcmp_r[PIF_CC2_MODE_LSB +: 2]);

   // Mode picks which timer event counts; PWM and off ignore both
   always_comb begin
      cc1_evt = 1'b0;
      cc2_evt = 1'b0;
      case (cc1_mode)
         PIF_CC_CAPTURE: cc1_evt = evt.cc1_capture; // see RULE7
         PIF_CC_COMPARE: cc1_evt = evt.cc1_compare; // see RULE7
         default:        cc1_evt = 1'b0;
      endcase
      case (cc2_mode)
         PIF_CC_CAPTURE: cc2_evt = evt.cc2_capture; // see RULE12
         PIF_CC_COMPARE: cc2_evt = evt.cc2_compare; // see RULE12
         default:        cc2_evt = 1'b0;
      endcase
   end

   // Only the rising edge of equality is an event, so a clear while the
   // timer still sits on its period value is not undone at once
   assign per_eq  = (evt.timer_two_count == evt.timer_two_period);
   assign per_hit = per_eq & ~per_eq_r; // see RULE8

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         per_eq_r <= 1'b0;
      end else if (ce) begin
         per_eq_r <= per_eq;
      end
   end

   // Set terms; no enable gates them anywhere in this block
   always_comb begin
      set_lo              = 8'h00; // see RULE10
      set_lo[PIF_LO_PSP]  = evt.psp_rw_done & ~PIN28; // see RULE1
      set_lo[PIF_LO_CONV] = evt.conv_done; // see RULE3
      set_lo[PIF_LO_SSP]  = evt.sync_serial_done; // see RULE6
      set_lo[PIF_LO_CC1]  = cc1_evt; // see RULE7
      set_lo[PIF_LO_PER]  = per_hit; // see RULE8
      set_lo[PIF_LO_T1OV] = evt.timer_one_ovf; // see RULE9
      set_hi              = 8'h00; // see RULE10
      set_hi[PIF_HI_OSCF] = evt.osc_fail; // see RULE12
      set_hi[PIF_HI_CMP]  = evt.comparator_change; // see RULE12
      set_hi[PIF_HI_NVM]  = evt.nvm_write_done; // see RULE12
      set_hi[PIF_HI_BCOL] = evt.bus_collision; // see RULE12
      set_hi[PIF_HI_VDET] = evt.voltage_detect; // see RULE12
      set_hi[PIF_HI_T3OV] = evt.timer_three_ovf; // see RULE12
      set_hi[PIF_HI_CC2]  = cc2_evt; // see RULE12
   end

   // Write replaces the writable bits, then a same-cycle event wins
   always_comb begin
      flags_lo_nxt = flags_lo_r;
      if (wr_take && sel_lo && lane0) begin
         flags_lo_nxt = (flags_lo_r & ~PIF_LO_WMASK) | (wbyte & PIF_LO_WMASK);
      end
      flags_lo_nxt = flags_lo_nxt | set_lo;
      // Mirrors track the serial holding registers, not software
      flags_lo_nxt[PIF_LO_RX] = evt.rx_holding_full; // see RULE4
      flags_lo_nxt[PIF_LO_TX] = evt.tx_holding_empty; // see RULE5
      if (PIN28) begin
         flags_lo_nxt[PIF_LO_PSP] = 1'b0; // see RULE2
      end
   end

   always_comb begin
      flags_hi_nxt = flags_hi_r;
      if (wr_take && sel_hi && lane0) begin
         flags_hi_nxt = (flags_hi_r & ~PIF_HI_WMASK) | (wbyte & PIF_HI_WMASK);
      end
      flags_hi_nxt = flags_hi_nxt | set_hi; // see RULE12
      flags_hi_nxt[PIF_HI_RSVD] = 1'b0; // see RULE12
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_lo_r <= PIF_FLAGS_LO_RST;
      end else if (ce) begin
         flags_lo_r <= flags_lo_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_hi_r <= PIF_FLAGS_HI_RST;
      end else if (ce) begin
         flags_hi_r <= flags_hi_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         capcmp_r <= PIF_CAPCMP_RST;
      end else if (ce && wr_take && sel_cc && lane0) begin
         capcmp_r <= wbyte[3:0];
      end
   end

   // Read data is captured in the idle cycle so it stands at the ack edge
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (sel_lo) begin
         rdata_nxt[7:0] = flags_lo_r;
      end else if (sel_hi) begin
         rdata_nxt[7:0] = flags_hi_r;
      end else if (sel_cc) begin
         rdata_nxt[3:0] = capcmp_r;
      end
   end

   // One wait cycle per access keeps every bus output a flop
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_r           <= PIF_BUS_IDLE;
         avs_waitrequest <= 1'b1;
      end else if (ce) begin
         case (bus_r)
            PIF_BUS_IDLE: begin
               if (req) begin
                  bus_r           <= PIF_BUS_ACK;
                  avs_waitrequest <= 1'b0;
               end
            end
            PIF_BUS_ACK: begin
               bus_r           <= PIF_BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_r           <= PIF_BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (ce && bus_r == PIF_BUS_IDLE && avs_read) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_readdata = rdata_r;
   assign flags_lo     = flags_lo_r;
   assign flags_hi     = flags_hi_r;

   // Checks

   AST_PSP_SET: assert property ( // see RULE1
      @(posedge ref_clk) disable iff (!reset_n)
      ce && evt.psp_rw_done && !PIN28 |=> flags_lo[PIF_LO_PSP])
      else $error("access flag missed a port transfer");

   AST_PSP_ZERO: assert property ( // see RULE2
      @(posedge ref_clk) disable iff (!reset_n)
      PIN28 |-> !flags_lo[PIF_LO_PSP] && (!avs_readdata[PIF_LO_PSP] || !$past(sel_lo)))
      else $error("access flag visible on small package");

   AST_CONV_HOLD: assert property ( // see RULE3
      @(posedge ref_clk) disable iff (!reset_n)
      flags_lo[PIF_LO_CONV] && !(ce && wr_take && sel_lo && lane0)
      |=> flags_lo[PIF_LO_CONV])
      else $error("conversion flag dropped without a write");

   AST_CONV_SET: assert property ( // see RULE3
      @(posedge ref_clk) disable iff (!reset_n)
      ce && evt.conv_done ##1 !ce [*2] |-> flags_lo[PIF_LO_CONV] && $stable(flags_lo))
      else $error("conversion flag lost or frozen state moved");

   AST_RX_MIRROR: assert property ( // see RULE4
      @(posedge ref_clk) disable iff (!reset_n)
      ce |=> flags_lo[PIF_LO_RX] == $past(evt.rx_holding_full))
      else $error("receive flag does not follow holding register");

   AST_TX_MIRROR: assert property ( // see RULE5
      @(posedge ref_clk) disable iff (!reset_n)
      ce && wr_take && sel_lo && lane0 |=>
      flags_lo[PIF_LO_TX] == $past(evt.tx_holding_empty))
      else $error("software write reached the transmit flag");

   AST_SSP_SET: assert property ( // see RULE6
      @(posedge ref_clk) disable iff (!reset_n)
      ce && evt.sync_serial_done |=> flags_lo[PIF_LO_SSP])
      else $error("serial done flag not set");

   AST_CC1_PWM: assert property ( // see RULE7
      @(posedge ref_clk) disable iff (!reset_n)
      ce && cc1_mode == PIF_CC_PWM && !flags_lo[PIF_LO_CC1] &&
      !(wr_take && sel_lo) |=> !flags_lo[PIF_LO_CC1])
      else $error("capture flag set in PWM mode");

   AST_CC1_CAP: assert property ( // see RULE7
      @(posedge ref_clk) disable iff (!reset_n)
      ce && cc1_mode == PIF_CC_CAPTURE && evt.cc1_capture |=> flags_lo[PIF_LO_CC1])
      else $error("capture event missed");

   AST_PER_SET: assert property ( // see RULE8
      @(posedge ref_clk) disable iff (!reset_n)
      ce && per_eq && !$past(per_eq) && $past(ce) |=> flags_lo[PIF_LO_PER])
      else $error("period match not flagged");

   AST_T1_SET: assert property ( // see RULE9
      @(posedge ref_clk) disable iff (!reset_n)
      ce && evt.timer_one_ovf && wr_take && sel_lo |=> flags_lo[PIF_LO_T1OV])
      else $error("overflow lost against a clearing write");

   AST_HI_RSVD: assert property ( // see RULE12
      @(posedge ref_clk) disable iff (!reset_n)
      !flags_hi[PIF_HI_RSVD])
      else $error("reserved high bit set");

   AST_HI_SET: assert property ( // see RULE10
      @(posedge ref_clk) disable iff (!reset_n)
      ce && evt.osc_fail |=>
      flags_hi[PIF_HI_OSCF])
      else $error("oscillator fail event not latched");

   AST_BUS_ACK: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      ce && req && avs_waitrequest |=> !avs_waitrequest ##1 (avs_waitrequest || !$past(ce)))
      else $error("bus answer not one cycle wide");

   AST_CC1_CMP: assert property ( // see RULE7
      @(posedge ref_clk) disable iff (!reset_n)
      ce && cc1_mode == PIF_CC_COMPARE && evt.cc1_compare |=> flags_lo[PIF_LO_CC1])
      else $error("compare match missed");

   AST_LO_HOLD: assert property ( // see RULE6
      @(posedge ref_clk) disable iff (!reset_n)
      !(ce && wr_take && sel_lo && lane0) |=>
      ($past(flags_lo) & ~flags_lo & PIF_LO_WMASK) == 8'h00)
      else $error("low flag dropped without a write");

   AST_HI_HOLD: assert property ( // see RULE12
      @(posedge ref_clk) disable iff (!reset_n)
      !(ce && wr_take && sel_hi && lane0) |=>
      ($past(flags_hi) & ~flags_hi) == 8'h00)
      else $error("high flag dropped without a write");

   AST_CC2_CAP: assert property ( // see RULE12
      @(posedge ref_clk) disable iff (!reset_n)
      ce && cc2_mode == PIF_CC_CAPTURE && evt.cc2_capture |=> flags_hi[PIF_HI_CC2])
      else $error("second capture event missed");

   AST_CMP_SET: assert property ( // see RULE12
      @(posedge ref_clk) disable iff (!reset_n)
      ce && evt.comparator_change |=> flags_hi[PIF_HI_CMP])
      else $error("comparator change not latched");

   AST_NVM_SET: assert property ( // see RULE12
      @(posedge ref_clk) disable iff (!reset_n)
      ce && evt.nvm_write_done |=> flags_hi[PIF_HI_NVM])
      else $error("write done not latched");

   AST_BCOL_SET: assert property ( // see RULE12
      @(posedge ref_clk) disable iff (!reset_n)
      ce && evt.bus_collision |=> flags_hi[PIF_HI_BCOL])
      else $error("bus collision not latched");

   AST_VDET_SET: assert property ( // see RULE12
      @(posedge ref_clk) disable iff (!reset_n)
      ce && evt.voltage_detect |=> flags_hi[PIF_HI_VDET])
      else $error("voltage event not latched");

   AST_T3_SET: assert property ( // see RULE12
      @(posedge ref_clk) disable iff (!reset_n)
      ce && evt.timer_three_ovf |=> flags_hi[PIF_HI_T3OV])
      else $error("third timer overflow not latched");

   AST_FREEZE: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      !ce |=> $stable(flags_lo) && $stable(flags_hi) && $stable(avs_waitrequest) &&
      $stable(avs_readdata))
      else $error("state moved while clock enable low");

endmodule // pif_irq_flags

// >>> test/pif_periph_model.sv
// Behavioural model of the peripherals that report events to the flag block
`timescale 1ns/1ps
module pif_periph_model
   import pif_pkg::*;
#(
   parameter logic [7:0] T2_PERIOD = 8'h05
) (
   input  wire logic     ref_clk,
   input  wire logic     reset_n,
   input  wire pif_evt_t req,
   input  wire logic     req_go,
   input  wire logic     t2_run,
   input  wire logic     rx_full,
   input  wire logic     tx_empty,
   output pif_evt_t      evt
);
   logic [7:0] t2_cnt_r;

   // Period starts away from the count so reset gives no false equality edge
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         evt                  <= '0;
         evt.timer_two_period <= T2_PERIOD;
      end else begin
         evt                  <= req_go ? req : '0;
         evt.rx_holding_full  <= rx_full;
         evt.tx_holding_empty <= tx_empty;
         evt.timer_two_count  <= t2_cnt_r;
         evt.timer_two_period <= T2_PERIOD;
      end
   end

   // Timer two wraps after matching its period, as a period timer does
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         t2_cnt_r <= 8'h00;
      end else if (t2_run) begin
         t2_cnt_r <= (t2_cnt_r == T2_PERIOD) ? 8'h00 : t2_cnt_r + 8'h01;
      end
   end
endmodule // pif_periph_model

// >>> test/pif_irq_flags_tb.sv
// Self-checking testbench for the peripheral interrupt flag block
`timescale 1ns/1ps
module pif_irq_flags_tb
   import pif_pkg::*;
;
   logic        ref_clk, reset_n, ce;
   logic [7:0]  avs_address;
   logic        avs_read, avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [7:0]  flags_lo, flags_hi, flags28;
   pif_evt_t    evt, req;
   logic        req_go, t2_run, rx_full, tx_empty;
   int          num_errors;
   int          num_checks;
   // Event bit inside evt and the flag bit it should set
   int          ev_pos[14] = '{31, 30, 27, 26, 25, 8, 7, 6, 5, 4, 3, 2, 1, 0};
   int          fl_bit[14] = '{7, 6, 3, 2, 2, 0, 7, 6, 4, 3, 2, 1, 0, 0};

   pif_irq_flags u_pif_irq_flags (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .evt(evt),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .flags_lo(flags_lo), .flags_hi(flags_hi));

   // Small-package variant shares the bus; only its low flag output is watched
   pif_irq_flags #(.PIN28(1'b1)) u_pif_irq_flags_28 (.ref_clk(ref_clk), .reset_n(reset_n),
      .ce(ce), .evt(evt), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(), .avs_waitrequest(), .flags_lo(flags28), .flags_hi());

   pif_periph_model u_pif_periph_model (.ref_clk(ref_clk), .reset_n(reset_n), .req(req),
      .req_go(req_go), .t2_run(t2_run), .rx_full(rx_full), .tx_empty(tx_empty), .evt(evt));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic end_of_test();
      if (num_errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Request is held until waitrequest is sampled low, then released
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address   <= a;
      avs_read      <= !w;
      avs_write     <= w;
      avs_writedata <= {24'h000000, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         num_errors++;
         end_of_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      logic [31:0] q;
      acc(1'b0, a, 8'h00, q);
      chk(name, {24'h000000, exp}, q);
   endtask

   task automatic fire(input pif_evt_t r);
      @(posedge ref_clk);
      req    <= r;
      req_go <= 1'b1;
      @(posedge ref_clk);
      req_go <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   initial begin
      logic [7:0] ofs;
      reset_n = 1'b0;
      ce = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
      req = '0;
      req_go = 1'b0;
      t2_run = 1'b0;
      rx_full = 1'b0;
      tx_empty = 1'b0;
      num_errors = 0;
      num_checks = 0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(PIF_OFS_FLAGS_LO, 8'h00, "flags_lo_reset");
      rd(PIF_OFS_FLAGS_HI, 8'h00, "flags_hi_reset");
      rd(8'h0C, 8'h00, "unmapped");
      // Each of the 14 pulse event sources once, capture and compare paths in their own modes
      for (int i = 0; i < 14; i++) begin
         ofs = (ev_pos[i] < 8) ? PIF_OFS_FLAGS_HI : PIF_OFS_FLAGS_LO;
         wr(PIF_OFS_CAPCMP, (ev_pos[i] == 25 || ev_pos[i] == 1) ? 8'h07 : 8'h0D);
         fire(pif_evt_t'(32'h1 << ev_pos[i]));
         rd(ofs, 8'h01 << fl_bit[i], "flag_set");
         if (i == 0) chk("flags_lo_28", 32'h0, {24'h000000, flags28});
         wr(ofs, 8'h00);
         rd(ofs, 8'h00, "flag_clear");
      end
      wr(PIF_OFS_CAPCMP, 8'h0A);
      fire(pif_evt_t'(32'h06000003));
      rd(PIF_OFS_FLAGS_LO, 8'h00, "pwm_lo");
      rd(PIF_OFS_FLAGS_HI, 8'h00, "pwm_hi");
      t2_run <= 1'b1;
      repeat (12) @(posedge ref_clk);
      t2_run <= 1'b0;
      rd(PIF_OFS_FLAGS_LO, 8'h02, "period_match");
      wr(PIF_OFS_FLAGS_LO, 8'h00);
      // Freeze: a latched conversion holds and a new receive level waits for ce
      req    <= pif_evt_t'(32'h40000000);
      req_go <= 1'b1;
      @(posedge ref_clk);
      req_go  <= 1'b0;
      rx_full <= 1'b1;
      @(posedge ref_clk);
      ce <= 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("frozen_lo", 32'h40, {24'h000000, flags_lo});
      @(posedge ref_clk);
      ce <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(PIF_OFS_FLAGS_LO, 8'h60, "thawed_lo");
      rx_full <= 1'b0;
      // Overflow lands on the edge that takes a clearing write: the set wins
      req <= pif_evt_t'(32'h00000100);
      fork
         wr(PIF_OFS_FLAGS_LO, 8'h00);
         begin
            @(posedge ref_clk);
            req_go <= 1'b1;
            @(posedge ref_clk);
            req_go <= 1'b0;
         end
      join
      rd(PIF_OFS_FLAGS_LO, 8'h01, "set_beats_clear");
      wr(PIF_OFS_FLAGS_LO, 8'h00);
      rx_full <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(PIF_OFS_FLAGS_LO, 8'h20, "rx_full");
      wr(PIF_OFS_FLAGS_LO, 8'h00);
      rd(PIF_OFS_FLAGS_LO, 8'h20, "rx_read_only");
      rx_full <= 1'b0;
      tx_empty <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(PIF_OFS_FLAGS_LO, 8'h10, "tx_empty");
      tx_empty <= 1'b0;
      repeat (3) @(posedge ref_clk);
      wr(PIF_OFS_FLAGS_LO, 8'hFF);
      rd(PIF_OFS_FLAGS_LO, 8'hCF, "lo_write_mask");
      chk("flags_lo_28_written", 32'h4F, {24'h000000, flags28});
      wr(PIF_OFS_FLAGS_HI, 8'hFF);
      rd(PIF_OFS_FLAGS_HI, 8'hDF, "hi_reserved");
      @(negedge ref_clk);
      chk("flags_hi_port", 32'hDF, {24'h000000, flags_hi});
      end_of_test();
   end
endmodule // pif_irq_flags_tb
